// ==== rtl/sctc_defines.vh ====
// Register offsets, field positions, reset values and timing figures of the clock control unit
`ifndef SCTC_DEFINES_VH
`define SCTC_DEFINES_VH

// Register byte offsets
`define SCTC_OFS_SRC_CFG 12'h000
`define SCTC_OFS_PLL_CFG 12'h004
`define SCTC_OFS_DIV_CFG 12'h008
`define SCTC_OFS_GATE_CFG 12'h00c
`define SCTC_OFS_STATUS 12'h010

// Source configuration fields
`define SCTC_SRC_SEL_LSB 0
`define SCTC_SRC_SEL_MSB 1
`define SCTC_SRC_RING_EN_BIT 2
`define SCTC_SRC_SYS_PLL_BIT 3

// Free-running clock source codes
`define SCTC_FR_RING 2'h0
`define SCTC_FR_REF 2'h1
`define SCTC_FR_EXT 2'h2

// PLL configuration fields
`define SCTC_PLL_EN_BIT 0
`define SCTC_PLL_BYPASS_BIT 1
`define SCTC_PLL_MULT_LSB 8
`define SCTC_PLL_MULT_MSB 15

// Divider fields
`define SCTC_DIV_AUX_LSB 0
`define SCTC_DIV_BUS_LSB 4
`define SCTC_DIV_PER_LSB 8

// Gate fields
`define SCTC_GATE_BUS_BIT 0
`define SCTC_GATE_PER_BIT 1

// Reset values
`define SCTC_RST_SRC_CFG 32'h0000_0004
`define SCTC_RST_PLL_CFG 32'h0000_0000
`define SCTC_RST_DIV_CFG 32'h0000_0000
`define SCTC_RST_GATE_CFG 32'h0000_0003

// Nominal frequencies in MHz
`define SCTC_RING_MHZ 20
`define SCTC_REF_MHZ 4
`define SCTC_EXT_MAX_MHZ 20

// AXI responses
`define SCTC_RESP_OKAY 2'h0
`define SCTC_RESP_SLVERR 2'h2

`endif

// ==== rtl/sctc_clock_control.v ====
// Clock source selection, PLL control and divided, gated clock enables
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sctc_defines.vh"

// Behaviour
// RQ1 - After reset system runs from ring oscillator
// RQ2 - Software can switch the ring oscillator off
// RQ3 - Ring oscillator feeds free clock and watchdog
// RQ4 - Reference selectable, PLL input, feeds power manager
// RQ5 - External clock via pin mux, selectable
// RQ6 - External feeds PLL only if accurate enough
// RQ7 - Free clock from exactly one source
// RQ8 - PLL never fed from ring oscillator
// RQ9 - Software keeps PLL within frequency ranges
// RQ10 - PLL enable, disable, bypass independent of ratio
// RQ11 - System clock from PLL or free clock
// RQ12 - Auxiliary and bus clocks get 3-bit dividers
// RQ13 - Peripheral clock from bus, divider and gate
// RQ14 - Auxiliary clock gated off in deep sleep
// RQ15 - Auxiliary clock offered only to PWM timer
// RQ16 - Bus clock to core, memory; divider, gate
// RQ17 - Divide by field plus one, change at boundary
// RQ18 - Muxes and gates switch without glitches
module sctc_clock_control
(
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Source ticks, each an asynchronous clock level sampled from outside the domain
   input wire ring_osc_tick,
   input wire trimmed_ref_tick,
   input wire external_clk_in,
   input wire pll_out_tick,
   // Deep sleep indication from the processor
   input wire deep_sleep,
   // Source and PLL controls
   output reg ring_oscillator_en,
   output reg pll_en,
   output reg pll_bypass,
   output reg [7:0] pll_mult,
   // Clock enables out of the tree
   output reg free_running_clk,
   output reg windowed_watchdog_clk,
   output reg power_manager_clk,
   output reg pwm_aux_clk,
   output reg bus_clk,
   output reg periph_clk
);

   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   reg [3:0] sync1; // First stage, read only by the second
   reg [3:0] sync2; // Second stage
   reg [3:0] sync_d; // Delayed for edge detection
   reg sleep_s1; // Sleep request first stage
   reg sleep_s2; // Sleep request second stage

   // Two flops per asynchronous input
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sync_d <= 4'h0;
         sleep_s1 <= 1'b0;
         sleep_s2 <= 1'b0;
      end
      else
      begin
         sync1 <= {pll_out_tick, external_clk_in, trimmed_ref_tick, ring_osc_tick};
         sync2 <= sync1;
         sync_d <= sync2;
         sleep_s1 <= deep_sleep;
         sleep_s2 <= sleep_s1;
      end
   end

   // Rising edges of each source become one-cycle enables
   wire [3:0] src_edge = sync2 & ~sync_d;

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   reg [31:0] src_cfg; // Source selection and ring enable
   reg [31:0] pll_cfg; // PLL enable, bypass, multiplier
   reg [31:0] div_cfg; // Three 3-bit divider fields
   reg [31:0] gate_cfg; // Software gates for bus and peripheral clocks

   // Byte-lane merge of a write into a register
   function [31:0] sctc_merge;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] strb;
      integer i;
      begin
         sctc_merge = old_val;
         for (i = 0; i < 4; i = i + 1)
            if (strb[i])
               sctc_merge[i*8 +: 8] = new_val[i*8 +: 8];
      end
   endfunction

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   reg aw_held; // Address captured, waiting for data
   reg w_held; // Data captured, waiting for address
   reg [11:0] aw_addr; // Captured write address
   reg [31:0] w_data; // Captured write data
   reg [3:0] w_strb; // Captured strobes
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire [11:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
   wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
   wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
   // Commit once both halves are in hand and no response pending
   wire wr_go = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;

   // Address and data accepted in either order, response after both
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SCTC_RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         src_cfg <= `SCTC_RST_SRC_CFG; // RQ1
         pll_cfg <= `SCTC_RST_PLL_CFG;
         div_cfg <= `SCTC_RST_DIV_CFG;
         gate_cfg <= `SCTC_RST_GATE_CFG;
      end
      else
      begin
         if (aw_take)
         begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `SCTC_RESP_OKAY;
            case (wr_addr)
               `SCTC_OFS_SRC_CFG: src_cfg <= sctc_merge(src_cfg, wr_data, wr_strb) & 32'h0000_000f;
               `SCTC_OFS_PLL_CFG: pll_cfg <= sctc_merge(pll_cfg, wr_data, wr_strb) & 32'h0000_ff03;
               `SCTC_OFS_DIV_CFG: div_cfg <= sctc_merge(div_cfg, wr_data, wr_strb) & 32'h0000_0777;
               `SCTC_OFS_GATE_CFG: gate_cfg <= sctc_merge(gate_cfg, wr_data, wr_strb) & 32'h0000_0003;
               `SCTC_OFS_STATUS: s_axi_bresp <= `SCTC_RESP_OKAY; // Read-only, write ignored
               default: s_axi_bresp <= `SCTC_RESP_SLVERR; // Unmapped address
            endcase
         end
         // Channels reopen once the response is taken
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Clock selection state
   // ------------------------------------------------------------
   reg [1:0] fr_sel; // Source currently passed to the free clock
   reg fr_idle; // Free clock held low during a source change
   reg sys_pll; // System clock taken from the PLL
   reg sys_idle; // System clock held low during a change
   reg pll_live; // PLL output in use on the PLL path
   reg [2:0] status_pulse; // Free clock phase, for status only

   wire [1:0] want_fr = src_cfg[`SCTC_SRC_SEL_MSB:`SCTC_SRC_SEL_LSB];
   wire want_pll = src_cfg[`SCTC_SRC_SYS_PLL_BIT];
   wire want_live = pll_cfg[`SCTC_PLL_EN_BIT] && !pll_cfg[`SCTC_PLL_BYPASS_BIT]; // RQ10

   // Pick one source tick; unused code falls back to the ring oscillator
   function sctc_pick;
      input [1:0] sel;
      input [3:0] ticks;
      begin
         case (sel)
            `SCTC_FR_REF: sctc_pick = ticks[1];
            `SCTC_FR_EXT: sctc_pick = ticks[2]; // RQ5
            default: sctc_pick = ticks[0];
         endcase
      end
   endfunction

   wire fr_tick = !fr_idle && sctc_pick(fr_sel, src_edge); // RQ7
   // PLL off or bypassed: the PLL path carries the free clock itself; the
   // path only swaps while the system mux idles, so ticks never crowd
   wire pll_path = pll_live ? src_edge[3] : fr_tick; // RQ10
   wire sys_tick = !sys_idle && (sys_pll ? pll_path : fr_tick); // RQ11

   // Source change: stop on a boundary, swap; free clock resumes on the new edge, system clock right after the swap
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fr_sel <= `SCTC_FR_RING; // RQ1
         fr_idle <= 1'b0;
         sys_pll <= 1'b0;
         sys_idle <= 1'b0;
         pll_live <= 1'b0;
      end
      else
      begin
         if (want_fr != fr_sel && !fr_idle)
            fr_idle <= 1'b1; // RQ18
         else if (fr_idle)
         begin
            fr_sel <= want_fr; // RQ7
            if (sctc_pick(want_fr, src_edge))
               fr_idle <= 1'b0; // RQ18
         end
         if ((want_pll != sys_pll || want_live != pll_live) && !sys_idle)
            sys_idle <= 1'b1; // RQ18
         else if (sys_idle)
         begin
            sys_pll <= want_pll; // RQ11
            pll_live <= want_live; // RQ10
            sys_idle <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Dividers
   // ------------------------------------------------------------
   reg [2:0] aux_cnt; // Auxiliary divider count
   reg [2:0] bus_cnt; // Bus divider count
   reg [2:0] per_cnt; // Peripheral divider count
   reg [2:0] aux_ratio; // Ratio latched at boundary
   reg [2:0] bus_ratio; // Ratio latched at boundary
   reg [2:0] per_ratio; // Ratio latched at boundary

   wire aux_wrap = sys_tick && aux_cnt == aux_ratio; // RQ17
   wire bus_wrap = sys_tick && bus_cnt == bus_ratio; // RQ17
   wire bus_en = bus_wrap && gate_cfg[`SCTC_GATE_BUS_BIT]; // RQ16
   wire per_wrap = bus_en && per_cnt == per_ratio; // RQ13

   // Count to field value then wrap, giving divide by value plus one;
   // new ratio only taken at a wrap so no short period appears
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aux_cnt <= 3'h0;
         bus_cnt <= 3'h0;
         per_cnt <= 3'h0;
         aux_ratio <= 3'h0;
         bus_ratio <= 3'h0;
         per_ratio <= 3'h0;
      end
      else
      begin
         if (aux_wrap)
         begin
            aux_cnt <= 3'h0;
            aux_ratio <= div_cfg[`SCTC_DIV_AUX_LSB +: 3]; // RQ17
         end
         else if (sys_tick)
            aux_cnt <= aux_cnt + 3'h1; // RQ12
         if (bus_wrap)
         begin
            bus_cnt <= 3'h0;
            bus_ratio <= div_cfg[`SCTC_DIV_BUS_LSB +: 3]; // RQ17
         end
         else if (sys_tick)
            bus_cnt <= bus_cnt + 3'h1; // RQ12
         if (per_wrap)
         begin
            per_cnt <= 3'h0;
            per_ratio <= div_cfg[`SCTC_DIV_PER_LSB +: 3]; // RQ17
         end
         else if (bus_en)
            per_cnt <= per_cnt + 3'h1; // RQ13
      end
   end

   // ------------------------------------------------------------
   // Registered clock enables out
   // ------------------------------------------------------------
   // Gates act on whole pulses, so none is ever cut short
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         free_running_clk <= 1'b0;
         windowed_watchdog_clk <= 1'b0;
         power_manager_clk <= 1'b0;
         pwm_aux_clk <= 1'b0;
         bus_clk <= 1'b0;
         periph_clk <= 1'b0;
         ring_oscillator_en <= 1'b1;
         pll_en <= 1'b0;
         pll_bypass <= 1'b0;
         pll_mult <= 8'h00;
         status_pulse <= 3'h0;
      end
      else
      begin
         free_running_clk <= fr_tick; // RQ7
         // Watchdog keeps its own ring path, independent of selection
         windowed_watchdog_clk <= src_edge[0] && src_cfg[`SCTC_SRC_RING_EN_BIT]; // RQ3
         power_manager_clk <= src_edge[1]; // RQ4
         pwm_aux_clk <= aux_wrap && !sleep_s2; // RQ14 RQ15
         bus_clk <= bus_en; // RQ16
         periph_clk <= per_wrap && gate_cfg[`SCTC_GATE_PER_BIT]; // RQ13
         ring_oscillator_en <= src_cfg[`SCTC_SRC_RING_EN_BIT]; // RQ2
         pll_en <= pll_cfg[`SCTC_PLL_EN_BIT]; // RQ10
         pll_bypass <= pll_cfg[`SCTC_PLL_BYPASS_BIT]; // RQ10
         pll_mult <= pll_cfg[`SCTC_PLL_MULT_MSB:`SCTC_PLL_MULT_LSB]; // RQ9
         if (fr_tick)
            status_pulse <= status_pulse + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   // Status shows what the tree really runs on, not what was asked
   wire [31:0] status_word = {20'h00000, 1'b0, status_pulse, 2'h0, sleep_s2, sys_idle,
      fr_idle, sys_pll, fr_sel};

   // One read at a time; answer one cycle after the address is taken
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SCTC_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `SCTC_RESP_OKAY;
         case (s_axi_araddr)
            `SCTC_OFS_SRC_CFG: s_axi_rdata <= src_cfg;
            `SCTC_OFS_PLL_CFG: s_axi_rdata <= pll_cfg;
            `SCTC_OFS_DIV_CFG: s_axi_rdata <= div_cfg;
            `SCTC_OFS_GATE_CFG: s_axi_rdata <= gate_cfg;
            `SCTC_OFS_STATUS: s_axi_rdata <= status_word;
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `SCTC_RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// ==== sim/sctc_checker.sv ====
// Port-level assertions for the clock control unit
`timescale 1ns/1ps
`default_nettype none
`include "sctc_defines.vh"
// ---------------------------------------------------------------
// Checker
// ---------------------------------------------------------------
module sctc_checker
(
   input wire aclk,
   input wire aresetn,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire ring_osc_tick,
   input wire trimmed_ref_tick,
   input wire external_clk_in,
   input wire deep_sleep,
   input wire ring_oscillator_en,
   input wire pll_en,
   input wire pll_bypass,
   input wire [7:0] pll_mult,
   input wire free_running_clk,
   input wire power_manager_clk,
   input wire pwm_aux_clk,
   input wire bus_clk,
   input wire periph_clk
);
   // Full-word write taken with both halves in one cycle
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && (s_axi_wstrb == 4'hf);
   reg [31:0] last_wd; // Last written word
   reg [1:0] gate_q; // Shadow of the gate register, reset open
   // Shadow registers, so the gate rules see what software asked for
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         last_wd <= 32'h0;
         gate_q <= 2'h3;
      end
      else if (wr_go)
      begin
         last_wd <= s_axi_wdata;
         if (s_axi_awaddr == `SCTC_OFS_GATE_CFG)
            gate_q <= s_axi_wdata[1:0];
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr(logic [11:0] a);
      wr_go && (s_axi_awaddr == a);
   endsequence
   sequence s_quiet;
      (!ring_osc_tick && !trimmed_ref_tick && !external_clk_in)[*6];
   endsequence
   property p_ring_ctl;
      s_wr(`SCTC_OFS_SRC_CFG) |-> ##[1:2] (ring_oscillator_en == last_wd[2]);
   endproperty
   a_ring_ctl: assert property (p_ring_ctl) else $error("ring enable wrong");
   property p_pll_ctl;
      s_wr(`SCTC_OFS_PLL_CFG) |-> ##[1:2] (pll_en == last_wd[0]
         && pll_bypass == last_wd[1] && pll_mult == last_wd[15:8]);
   endproperty
   a_pll_ctl: assert property (p_pll_ctl) else $error("PLL controls wrong");
   property p_ref_only;
      (!trimmed_ref_tick)[*6] |-> !power_manager_clk;
   endproperty
   a_ref_only: assert property (p_ref_only) else $error("power clock w/o ref");
   property p_free_quiet;
      s_quiet |-> !free_running_clk;
   endproperty
   a_free_quiet: assert property (p_free_quiet) else $error("free clock w/o source");
   property p_aux_sleep;
      deep_sleep[*6] |-> !pwm_aux_clk;
   endproperty
   a_aux_sleep: assert property (p_aux_sleep) else $error("aux clock in sleep");
   property p_bus_gate;
      (!gate_q[0])[*8] |-> !bus_clk;
   endproperty
   a_bus_gate: assert property (p_bus_gate) else $error("bus clock through gate");
   property p_per_gate;
      (!gate_q[1])[*8] |-> !periph_clk;
   endproperty
   a_per_gate: assert property (p_per_gate) else $error("periph clock through gate");
   property p_no_runt;
      (bus_clk |=> !bus_clk) and (pwm_aux_clk |=> !pwm_aux_clk);
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("back-to-back pulses");
endmodule
bind sctc_clock_control sctc_checker i_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .ring_osc_tick,
   .trimmed_ref_tick, .external_clk_in, .deep_sleep, .ring_oscillator_en, .pll_en,
   .pll_bypass, .pll_mult, .free_running_clk, .power_manager_clk, .pwm_aux_clk, .bus_clk,
   .periph_clk);
`default_nettype wire

// ==== sim/sctc_src_model.sv ====
// Behavioural clock sources: ring, reference, external input and PLL
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// Source model, rates scaled so aclk can sample every edge
// ---------------------------------------------------------------
module sctc_src_model
#(
   parameter int RH = 130,
   parameter int FH = 310,
   parameter int EH = 170,
   parameter int PH = 90
)
(
   input wire logic ring_en,
   input wire logic ext_on,
   input wire logic pll_on,
   output logic ring_clk,
   output logic ref_clk,
   output logic ext_clk,
   output logic pll_clk
);
   initial {ring_clk, ref_clk, ext_clk, pll_clk} = 4'h0;
   // Ring stops low when switched off
   always #RH ring_clk = (ring_en === 1'b1) ? ~ring_clk : 1'b0;
   // Reference never stops
   always #FH ref_clk = ~ref_clk;
   // Exact period, well inside the accuracy limit
   always #EH ext_clk = (ext_on === 1'b1) ? ~ext_clk : 1'b0;
   // Fixed output rate, as if programmed inside its range
   always #PH pll_clk = (pll_on === 1'b1) ? ~pll_clk : 1'b0;
endmodule
`default_nettype wire

// ==== sim/system_clock_tree_control_tb.sv ====
// Self-checking testbench of the clock control unit
`timescale 1ns/1ps
`default_nettype none
`include "sctc_defines.vh"
module system_clock_tree_control_tb;
   localparam int RH = 130; // Source half periods in ns
   localparam int FH = 310;
   localparam int EH = 170;
   localparam int PH = 90;
   localparam int W = 1040; // Counting window in cycles
   logic aclk, aresetn, awvalid, wvalid, arvalid, deep_sleep, ext_on;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb; // Byte lanes of the next write
   wire awready, wready, bvalid, arready, rvalid, ring_en, pll_en, pll_bypass;
   wire ring_c, ref_c, ext_c, pll_c;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [7:0] pll_mult;
   wire [5:0] pul; // Free, watchdog, power, aux, bus, periph pulses
   int err_total, n_checks;
   int cnt [6];
   int d [6];
   sctc_clock_control i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .ring_osc_tick(ring_c), .trimmed_ref_tick(ref_c), .external_clk_in(ext_c),
      .pll_out_tick(pll_c), .deep_sleep(deep_sleep), .ring_oscillator_en(ring_en),
      .pll_en(pll_en), .pll_bypass(pll_bypass), .pll_mult(pll_mult),
      .free_running_clk(pul[0]), .windowed_watchdog_clk(pul[1]),
      .power_manager_clk(pul[2]), .pwm_aux_clk(pul[3]), .bus_clk(pul[4]), .periph_clk(pul[5]));
   sctc_src_model #(.RH(RH), .FH(FH), .EH(EH), .PH(PH)) i_src (.ring_en(ring_en),
      .ext_on(ext_on), .pll_on(pll_en), .ring_clk(ring_c), .ref_clk(ref_c),
      .ext_clk(ext_c), .pll_clk(pll_c));
   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // Consumers count every enable pulse
   always @(posedge aclk)
      for (int i = 0; i < 6; i++) cnt[i] += (pul[i] === 1'b1);
   function int rate(input int half);
      return W * 20 / half;
   endfunction
   task finish_test;
      $display("Checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Pulse counts are allowed two of slack for the async phase
   task near(input int got, input int exp);
      n_checks++;
      if (got > exp + 2 || got < exp - 2)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task measure(input int pre);
      int s [6];
      repeat (pre) @(posedge aclk);
      s = cnt;
      repeat (W) @(posedge aclk);
      foreach (d[i]) d[i] = cnt[i] - s[i];
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      if (bvalid !== 1'b1)
      begin
         err_total++;
         finish_test;
      end
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ev, input logic [1:0] er,
      input logic [31:0] msk = 32'hffff_ffff);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do
      begin
         @(posedge aclk);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      if (rvalid !== 1'b1)
      begin
         err_total++;
         finish_test;
      end
      chk(rdata & msk, ev);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // Reset values, unmapped access, clocks straight from the ring and the reference
   task t_reset;
      rd(`SCTC_OFS_SRC_CFG, `SCTC_RST_SRC_CFG, `SCTC_RESP_OKAY);
      rd(`SCTC_OFS_GATE_CFG, `SCTC_RST_GATE_CFG, `SCTC_RESP_OKAY);
      rd(12'h020, 32'h0, `SCTC_RESP_SLVERR);
      wr(12'h020, 32'hffff_ffff, `SCTC_RESP_SLVERR);
      wr(`SCTC_OFS_STATUS, 32'h0, `SCTC_RESP_OKAY);
      measure(10);
      near(d[0], rate(RH));
      near(d[1], rate(RH));
      near(d[2], rate(FH));
      near(d[4], rate(RH));
   endtask
   // Every free-running source code in turn
   task t_src;
      logic [1:0] cd [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
      int hf [4] = '{FH, EH, RH, RH};
      for (int k = 0; k < 4; k++)
      begin
         wr(`SCTC_OFS_SRC_CFG, {30'h1, cd[k]}, `SCTC_RESP_OKAY);
         measure(40);
         near(d[0], rate(hf[k]));
         near(d[4], rate(hf[k]));
         near(d[1], rate(RH));
      end
   endtask
   // Ring switched off while the reference runs the tree
   task t_ring_off;
      wr(`SCTC_OFS_SRC_CFG, 32'h1, `SCTC_RESP_OKAY);
      ext_on <= 1'b0;
      measure(20);
      chk({31'h0, ring_en}, 32'h0);
      near(d[1], 0);
      near(d[0], rate(FH));
      ext_on <= 1'b1;
      wr(`SCTC_OFS_SRC_CFG, 32'h4, `SCTC_RESP_OKAY);
      measure(20);
      near(d[0], rate(RH));
   endtask
   // PLL fed from the reference, then bypassed
   task t_pll;
      wr(`SCTC_OFS_SRC_CFG, 32'h5, `SCTC_RESP_OKAY);
      wr(`SCTC_OFS_PLL_CFG, 32'h4b01, `SCTC_RESP_OKAY);
      wr(`SCTC_OFS_SRC_CFG, 32'hd, `SCTC_RESP_OKAY);
      measure(40);
      chk({22'h0, pll_mult, pll_bypass, pll_en}, 32'h12d);
      near(d[4], rate(PH));
      near(d[0], rate(FH));
      rd(`SCTC_OFS_STATUS, 32'h5, `SCTC_RESP_OKAY, 32'hff);
      wr(`SCTC_OFS_PLL_CFG, 32'h4b03, `SCTC_RESP_OKAY);
      measure(40);
      chk({24'h0, pll_mult}, 32'h4b);
      near(d[4], rate(FH));
      wr(`SCTC_OFS_PLL_CFG, 32'h0, `SCTC_RESP_OKAY);
      wr(`SCTC_OFS_SRC_CFG, 32'h4, `SCTC_RESP_OKAY);
   endtask
   // Three dividers at different ratios
   task t_div;
      wr(`SCTC_OFS_DIV_CFG, 32'h212, `SCTC_RESP_OKAY);
      measure(40);
      near(d[3], rate(RH) / 3);
      near(d[4], rate(RH) / 2);
      near(d[5], rate(RH) / 6);
      rd(`SCTC_OFS_DIV_CFG, 32'h212, `SCTC_RESP_OKAY);
      wstrb <= 4'h2;
      wr(`SCTC_OFS_DIV_CFG, 32'h0, `SCTC_RESP_OKAY);
      wstrb <= 4'hf;
      rd(`SCTC_OFS_DIV_CFG, 32'h012, `SCTC_RESP_OKAY);
      wr(`SCTC_OFS_DIV_CFG, 32'h0, `SCTC_RESP_OKAY);
   endtask
   // Software gates, then deep sleep on the auxiliary clock
   task t_gate;
      repeat (40) @(posedge aclk);
      wr(`SCTC_OFS_GATE_CFG, 32'h0, `SCTC_RESP_OKAY);
      measure(20);
      near(d[4], 0);
      near(d[5], 0);
      near(d[3], rate(RH));
      deep_sleep <= 1'b1;
      measure(20);
      near(d[3], 0);
      rd(`SCTC_OFS_STATUS, 32'h20, `SCTC_RESP_OKAY, 32'hff);
      near(d[0], rate(RH));
      deep_sleep <= 1'b0;
      wr(`SCTC_OFS_GATE_CFG, 32'h3, `SCTC_RESP_OKAY);
      measure(20);
      near(d[5], rate(RH));
   endtask
   initial
   begin
      aresetn <= 1'b0;
      {awvalid, wvalid, arvalid, deep_sleep} <= 4'h0;
      ext_on <= 1'b1;
      awaddr <= 12'h0;
      araddr <= 12'h0;
      wdata <= 32'h0;
      wstrb <= 4'hf;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset;
      t_src;
      t_ring_off;
      t_pll;
      t_div;
      t_gate;
      finish_test;
   end
endmodule
`default_nettype wire
